// file: logic/sdw_pkg.sv
/*
  package for the serial dac word input block: widths, codes, pin levels.
  assumes nothing of its surroundings; imported by sdw_top.
*/
package sdw_pkg;
  // ----------------------------------------------------------------
  // word format
  // ----------------------------------------------------------------
  localparam int SDW_WORD_W = 24;          // converter code width
  localparam int SDW_SHORT_W = 20;         // short word length
  localparam int SDW_PAD_W = SDW_WORD_W - SDW_SHORT_W; // zero fill bits
  localparam logic [23:0] SDW_NEG_FS = 24'h800000; // negative full scale
  localparam logic [23:0] SDW_POS_FS = 24'h7FFFFF; // positive full scale
  localparam logic [23:0] SDW_ZERO = 24'h000000;   // bipolar zero
  // ----------------------------------------------------------------
  // link timing
  // ----------------------------------------------------------------
  localparam int SDW_CLK_MHZ = 250;        // ref_clk rate
  localparam int SDW_BCLK_MAX_MHZ = 25;    // highest bit clock rate
  // fewest ref_clk cycles in one bit clock period (rounded down)
  localparam int SDW_BCLK_MIN_CYC = SDW_CLK_MHZ / SDW_BCLK_MAX_MHZ;
  // ----------------------------------------------------------------
  // pins and states
  // ----------------------------------------------------------------
  localparam logic SDW_LONG_SEL = 1'b1;    // word length pin high: 24 bit
  localparam logic SDW_NORMAL_SEL = 1'b1;  // polarity pin high: normal

  typedef struct packed {
    logic data;                            // serial data
    logic bclk;                            // bit clock
    logic latch;                           // word latch strobe
  } sdw_link_s;

  typedef struct packed {
    logic word_length_select;              // high: 24 bit, low: 20 bit
    logic polarity_select;                 // high: normal, low: inverted
  } sdw_strap_s;

  typedef enum logic [1:0] {
    SDW_IDLE = 2'b00,                      // no transfer waiting
    SDW_WAIT1 = 2'b01,                     // latched, first rise awaited
    SDW_WAIT2 = 2'b10                      // second rise updates output
  } sdw_state_e;
endpackage

// file: logic/sdw_top.sv
/*
  serial dac word input: shifts serial samples in on the bit clock,
  latches them on the strobe falling edge and presents the code.
  assumes link pins are asynchronous to ref_clk and the bit clock is at
  most a tenth of ref_clk; strap pins are pulled up outside.
*/
// Functional notes
// RL1: samples are two's complement, msb first
// RL2: only last 24 shifted bits are latched
// RL3: code maps linearly, 800000 negative full scale
// RL4: data sampled on each bit clock rise
// RL5: strobe fall copies shift register to latch
// RL6: output updates on second rise after fall
// RL7: bit clock at most 25 MHz
// RL8: far end sends 32-bit frames
// RL9: stopped bit clock keeps shifted bits
// RL10: strobe stays low past next first bit
// RL11: strobe phases longer than one bit period
// RL12: word length pin high 24, low 20
// RL13: unconnected word length pin means 24 bit
// RL14: polarity pin high normal, low inverted
// RL15: unconnected polarity pin means normal
// RL16: 20-bit words zero-fill four low bits
// RL17: inversion negates, saturating negative full scale
`timescale 1ns/10ps
module sdw_top
  import sdw_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // serial link from the interpolation filter
  input wire sdw_link_s link_in,
  // static format pins, pulled up outside (see RL13) (see RL15)
  input wire sdw_strap_s strap_in,
  // converter code
  output logic [SDW_WORD_W-1:0] dac_code_q,
  output logic dac_update_q
);
  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  sdw_link_s link_s1_q, link_s2_q, link_s3_q; // s3 holds previous level
  sdw_strap_s strap_s1_q, strap_s2_q;

  // two flops per pin, third stage only for edge finding
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link_s1_q <= '0;
      link_s2_q <= '0;
      link_s3_q <= '0;
      strap_s1_q <= '1; // pulled-up defaults (see RL13) (see RL15)
      strap_s2_q <= '1;
    end else begin
      link_s1_q <= link_in;
      link_s2_q <= link_s1_q;
      link_s3_q <= link_s2_q;
      strap_s1_q <= strap_in;
      strap_s2_q <= strap_s1_q;
    end
  end

  logic bclk_rise;                        // bit clock rising edge seen
  logic latch_fall;                       // strobe falling edge seen
  assign bclk_rise = link_s2_q.bclk & ~link_s3_q.bclk;
  assign latch_fall = ~link_s2_q.latch & link_s3_q.latch;

  // ----------------------------------------------------------------
  // shift, latch and output path
  // ----------------------------------------------------------------
  logic [SDW_WORD_W-1:0] shift_q, shift_d;   // serial register
  logic [SDW_WORD_W-1:0] latch_q, latch_d;   // parallel register
  logic [SDW_WORD_W-1:0] dac_code_d;
  logic dac_update_d;
  sdw_state_e state_q, state_d;
  logic [SDW_WORD_W-1:0] word_fmt;           // length-formatted sample
  logic [SDW_WORD_W-1:0] word_out;           // phase-applied sample

  // next-state logic for the whole data path
  always_comb begin
    shift_d = shift_q;
    latch_d = latch_q;
    state_d = state_q;
    dac_code_d = dac_code_q;
    dac_update_d = 1'b0;
    word_fmt = latch_q;
    word_out = latch_q;
    // msb enters first and ends on top; shift only on a rise,
    // so a stopped clock simply holds the bits (see RL4) (see RL1) (see RL9)
    if (bclk_rise) begin
      shift_d = {shift_q[SDW_WORD_W-2:0], link_s2_q.data};
    end
    // length select: short words take the low 20 shifted bits (see RL12)
    if (strap_s2_q.word_length_select != SDW_LONG_SEL) begin
      word_fmt = {latch_q[SDW_SHORT_W-1:0], {SDW_PAD_W{1'b0}}}; // see RL16
    end
    // polarity: negation saturates the one code with no opposite
    if (strap_s2_q.polarity_select != SDW_NORMAL_SEL) begin // see RL14
      if (word_fmt == SDW_NEG_FS) begin
        word_out = SDW_POS_FS;            // see RL17
      end else begin
        word_out = SDW_ZERO - word_fmt;   // see RL17
      end
    end else begin
      word_out = word_fmt;
    end
    case (state_q)
      SDW_IDLE: begin
        // a rise in the same sample edge is taken as the shift's own
        if (latch_fall) begin
          latch_d = shift_q;              // last 24 bits (see RL5) (see RL2)
          state_d = SDW_WAIT1;
        end
      end
      SDW_WAIT1: begin
        if (bclk_rise) begin
          state_d = SDW_WAIT2;
        end
      end
      SDW_WAIT2: begin
        if (bclk_rise) begin
          // output code changes on the second rise (see RL6) (see RL3)
          dac_code_d = word_out;
          dac_update_d = 1'b1;
          state_d = SDW_IDLE;
        end
      end
      default: begin
        state_d = SDW_IDLE;
      end
    endcase
  end

  // registers of the data path
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= '0;
      latch_q <= '0;
      state_q <= SDW_IDLE;
      dac_code_q <= SDW_ZERO;             // start at bipolar zero
      dac_update_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      latch_q <= latch_d;
      state_q <= state_d;
      dac_code_q <= dac_code_d;
      dac_update_q <= dac_update_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  update_on_rise_a: assert property ( // see RL6
    @(posedge ref_clk) disable iff (!resetn)
    dac_update_q |-> $past(bclk_rise) && $past(state_q) == SDW_WAIT2)
    else $error("output update not on second bit clock rise");

  latch_takes_shift_a: assert property ( // see RL5
    @(posedge ref_clk) disable iff (!resetn)
    (latch_fall && state_q == SDW_IDLE) |=> latch_q == $past(shift_q))
    else $error("strobe fall did not latch shift register");

  shift_in_msb_a: assert property ( // see RL4
    @(posedge ref_clk) disable iff (!resetn)
    bclk_rise |=> shift_q[0] == $past(link_s2_q.data)
      && shift_q[SDW_WORD_W-1:1] == $past(shift_q[SDW_WORD_W-2:0]))
    else $error("bit not shifted in on bit clock rise");

  hold_when_stopped_a: assert property ( // see RL9
    @(posedge ref_clk) disable iff (!resetn)
    !bclk_rise |=> $stable(shift_q))
    else $error("shift register moved without a bit clock rise");

  code_stable_a: assert property ( // see RL3
    @(posedge ref_clk) disable iff (!resetn)
    !dac_update_q |-> $stable(dac_code_q))
    else $error("output code changed without update");

  short_zero_fill_a: assert property ( // see RL16
    @(posedge ref_clk) disable iff (!resetn)
    (dac_update_q && !$past(strap_s2_q.word_length_select)
      && $past(strap_s2_q.polarity_select))
      |-> dac_code_q[SDW_PAD_W-1:0] == '0)
    else $error("short word low bits not zero");

  invert_sat_a: assert property ( // see RL17
    @(posedge ref_clk) disable iff (!resetn)
    (dac_update_q && !$past(strap_s2_q.polarity_select)
      && $past(strap_s2_q.word_length_select)
      && $past(latch_q) == SDW_NEG_FS) |-> dac_code_q == SDW_POS_FS)
    else $error("inverted negative full scale not saturated");

  normal_pass_a: assert property ( // see RL14
    @(posedge ref_clk) disable iff (!resetn)
    (dac_update_q && $past(strap_s2_q.polarity_select)
      && $past(strap_s2_q.word_length_select))
      |-> dac_code_q == $past(latch_q))
    else $error("normal phase long word not passed unchanged");

  wait_bounded_a: assert property ( // see RL6
    @(posedge ref_clk) disable iff (!resetn)
    (state_q == SDW_WAIT1 && bclk_rise) |=> state_q == SDW_WAIT2)
    else $error("first bit clock rise not counted");

  // short word must land in the upper bits, not only leave zeros below
  short_upper_bits_a: assert property ( // see RL16
    @(posedge ref_clk) disable iff (!resetn)
    (dac_update_q && !$past(strap_s2_q.word_length_select)
      && $past(strap_s2_q.polarity_select))
      |-> dac_code_q[SDW_WORD_W-1:SDW_PAD_W]
        == $past(latch_q[SDW_SHORT_W-1:0]))
    else $error("short word not placed in upper bits");

  // every code other than negative full scale has an exact opposite
  invert_negate_a: assert property ( // see RL17
    @(posedge ref_clk) disable iff (!resetn)
    (dac_update_q && !$past(strap_s2_q.polarity_select)
      && $past(strap_s2_q.word_length_select)
      && $past(latch_q) != SDW_NEG_FS)
      |-> dac_code_q == SDW_ZERO - $past(latch_q))
    else $error("inverted long word not negated");

  // the parallel register moves only on an accepted strobe fall, so a
  // fall while an update is pending cannot disturb the waiting word
  latch_only_on_fall_a: assert property ( // see RL5
    @(posedge ref_clk) disable iff (!resetn)
    !(latch_fall && state_q == SDW_IDLE) |=> $stable(latch_q))
    else $error("parallel register changed without strobe fall");
endmodule // sdw_top

// file: test/sdw_filter_model.sv
/*
  behavioural interpolation filter model: sends 32-bit frames msb first.
  assumes the bench holds frame_word while busy is high.
*/
`timescale 1ns/10ps
module sdw_filter_model
  import sdw_pkg::*;
(
  // bench side
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [31:0] frame_word,
  output logic busy,
  // link toward the block
  output sdw_link_s link_out
);
  // ----------------------------------------------------------------
  // frame engine, bit clock stands still between frames
  // ----------------------------------------------------------------
  initial begin
    busy = 1'b0;
    link_out = '{data: 1'b0, bclk: 1'b0, latch: 1'b1};
  end
  // offset of 1.3 ns keeps link edges off the sampling edge
  always @(posedge ref_clk) begin
    if (go === 1'b1) begin
      #1.3 busy = 1'b1;
      for (int i = 31; i >= 0; i--) begin
        link_out.data = frame_word[i];
        // strobe low past first bit, both phases long
        if (i == 27) link_out.latch = 1'b1;
        #40 link_out.bclk = 1'b1; // 80 ns period
        #40 link_out.bclk = 1'b0;
      end
      #20 link_out.latch = 1'b0;
      // released line must not keep showing the last bit
      link_out.data = ~frame_word[0];
      busy = 1'b0;
    end
  end
endmodule // sdw_filter_model

// file: test/sdw_top_tb.sv
/*
  self-checking bench for sdw_top: frames from the filter model, codes
  checked against a queue of expected values.
  assumes the filter model in the same test folder.
*/
`timescale 1ns/10ps
module sdw_top_tb;
  import sdw_pkg::*;
  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic go = 1'b0;
  logic busy;
  logic [31:0] frame_word = '0;
  sdw_link_s link;
  sdw_strap_s strap = '{word_length_select: 1'b1, polarity_select: 1'b1};
  logic [23:0] dac_code_q;
  logic dac_update_q;
  logic [23:0] expq[$];
  logic [23:0] exp_v;
  logic [31:0] prev_word;
  logic [23:0] tbl[4] = '{SDW_NEG_FS, SDW_ZERO, 24'hFFFFFF, SDW_POS_FS};
  int fails = 0;
  int comparisons = 0;

  sdw_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .link_in(link),
    .strap_in(strap), .dac_code_q(dac_code_q), .dac_update_q(dac_update_q));
  sdw_filter_model u_filter (.ref_clk(ref_clk), .go(go),
    .frame_word(frame_word), .busy(busy), .link_out(link));

  initial forever #2 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // expected code: word length, then phase with saturation
  // ----------------------------------------------------------------
  function automatic logic [23:0] exp_code(logic [31:0] w, sdw_strap_s s);
    logic [23:0] c;
    c = s.word_length_select ? w[23:0] : {w[19:0], 4'h0};
    if (!s.polarity_select) c = (c == SDW_NEG_FS) ? SDW_POS_FS : -c;
    return c;
  endfunction

  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one frame; straps change with it and apply to the pending word
  task automatic send(logic [31:0] w, sdw_strap_s s, bit first);
    @(posedge ref_clk);
    frame_word <= w;
    strap <= s;
    go <= 1'b1;
    if (!first) expq.push_back(exp_code(prev_word, s));
    prev_word = w;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    while (busy) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // output watcher: oldest note against each update
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (dac_update_q === 1'b1) begin
      comparisons++;
      exp_v = (expq.size() > 0) ? expq.pop_front() : 'x;
      if (dac_code_q !== exp_v) begin
        fails++;
        $display("Error dac_code_q expected %h seen %h", exp_v, dac_code_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] w;
    void'($urandom(32'h633bebd3));
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    comparisons++;
    if (dac_code_q !== SDW_ZERO) begin
      fails++;
      $display("Error reset code expected %h seen %h", SDW_ZERO, dac_code_q);
    end
    for (int i = 0; i < 36; i++) begin
      w = $urandom;
      if (i < 16) w[23:0] = tbl[i % 4];
      send(w, (i < 16) ? i[3:2] : 2'($urandom), i == 0);
      repeat ($urandom_range(1, 30)) @(posedge ref_clk);
    end
    repeat (20) @(posedge ref_clk);
    comparisons++;
    // last word stays latched with the clock stopped; nothing queued
    if (expq.size() !== 0) begin
      fails++;
      $display("Error pending updates expected 0 seen %0d", expq.size());
    end
    stop_test();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    $display("Error watchdog expected done seen hang");
    stop_test();
  end
endmodule // sdw_top_tb
